// ---- hw/uep_cfg.svh ----
`ifndef UEP_CFG_SVH
`define UEP_CFG_SVH
// Standard request codes
`define UEP_REQ_GET_STATUS    8'h00
`define UEP_REQ_CLR_FEATURE   8'h01
`define UEP_REQ_SET_FEATURE   8'h03
`define UEP_REQ_SET_ADDRESS   8'h05
`define UEP_REQ_GET_DESC      8'h06
`define UEP_REQ_SET_DESC      8'h07
`define UEP_REQ_GET_CONFIG    8'h08
`define UEP_REQ_SET_CONFIG    8'h09
`define UEP_REQ_GET_INTF      8'h0A
`define UEP_REQ_SET_INTF      8'h0B
`define UEP_REQ_SYNCH_FRAME   8'h0C
// Feature selectors
`define UEP_FEAT_EP_HALT      16'h0000
`define UEP_FEAT_REMOTE_WAKE  16'h0001
// Descriptor types
`define UEP_DESC_INTERFACE    8'h04
`define UEP_DESC_ENDPOINT     8'h05
// Sizes
`define UEP_SETUP_BYTES       4'd8
`define UEP_NUM_EP            16
`define UEP_NUM_CONFIGS       2'd3
`define UEP_MPS_INT           9'd8
`define UEP_MPS_BULK          9'd64
`define UEP_MPS_ISO           9'd256
`define UEP_MPS_CTRL          9'd8
// Endpoint types, two bits per endpoint, and fixed directions, one bit per endpoint
`define UEP_EP_TYPES          32'hB6DB_6DB4
`define UEP_EP_DIR_IN         16'hAAAA
`endif

// ---- hw/uep_pkg.sv ----
package uep_pkg;
  typedef enum logic [1:0] {
    UEP_TOK_SETUP,
    UEP_TOK_IN,
    UEP_TOK_OUT
  } uep_tok_t;
  typedef enum logic [1:0] {
    UEP_HS_ACK,
    UEP_HS_NAK,
    UEP_HS_STALL,
    UEP_HS_NONE
  } uep_hs_t;
  // Token from the link layer
  typedef struct packed {
    uep_tok_t   kind;
    logic [6:0] addr;
    logic [3:0] ep;
  } uep_token_t;
  // Decoded setup packet
  typedef struct packed {
    logic [7:0]  reqType;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } uep_setup_t;
  // Handshake answer
  typedef struct packed {
    uep_hs_t hs;
    logic    dataPid1;
  } uep_answer_t;
endpackage : uep_pkg

// ---- hw/uep_setup_collect.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uep_cfg.svh"
// Collects the eight setup bytes into one request word
module uep_setup_collect (
  input  wire logic              clk,
  input  wire logic              rstN,
  input  wire logic              start,
  input  wire logic              byteValid,
  input  wire logic [7:0]        byteData,
  input  wire logic              pktEnd,
  output var  uep_pkg::uep_setup_t setupPkt,
  output logic                   setupDone
);
  logic [63:0] shift_r;
  logic [63:0] shift_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        done_r;
  logic        done_nxt;

  // Byte count and shifter; a short or long packet gives no request
  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    if (start) begin
      cnt_nxt = 4'h0;
    end else if (byteValid && cnt_r != 4'hF) begin
      shift_nxt = {byteData, shift_r[63:8]};
      cnt_nxt   = cnt_r + 4'h1;
    end else if (pktEnd) begin
      done_nxt = (cnt_r == `UEP_SETUP_BYTES);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      shift_r <= 64'h0000_0000_0000_0000;
      cnt_r   <= 4'h0;
      done_r  <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  // Little-endian wire order into the fields
  assign setupPkt.reqType = shift_r[7:0];
  assign setupPkt.request = shift_r[15:8];
  assign setupPkt.value   = shift_r[31:16];
  assign setupPkt.index   = shift_r[47:32];
  assign setupPkt.length  = shift_r[63:48];
  assign setupDone        = done_r;
endmodule : uep_setup_collect
`default_nettype wire

// ---- hw/uep_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uep_cfg.svh"
module uep_ctrl (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 selfPowered,
  input  wire logic                 tokValid,
  input  var  uep_pkg::uep_token_t  tok,
  input  wire logic                 rxByteValid,
  input  wire logic [7:0]           rxByte,
  input  wire logic                 rxPktEnd,
  input  wire logic                 rxPktOk,
  input  wire logic                 hostAck,
  input  wire logic                 sofValid,
  input  wire logic [10:0]          sofFrame,
  input  wire logic                 fwAnswer,
  input  wire logic                 fwStall,
  output logic                      ansValid,
  output var  uep_pkg::uep_answer_t ans,
  output logic [15:0]               txWord,
  output logic                      fwSetupValid,
  output var  uep_pkg::uep_setup_t  fwSetup,
  output logic [6:0]                devAddr,
  output logic [1:0]                configSlot,
  output logic [7:0]                altSetting,
  output logic [10:0]               frameCount,
  output logic [15:0]               epHalted,
  output logic                      remoteWake,
  output logic [8:0]                epMaxPkt
);
  logic rstS1_r, rstS2_r, rstN, selfS1_r, selfS2_r;
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstS1_r <= 1'b0;
      rstS2_r <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstS2_r <= rstS1_r;
    end
  end
  assign rstN = rstS2_r;

  // Self-power level comes from a board pin, so it is synchronised first
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      selfS1_r <= 1'b0;
      selfS2_r <= 1'b0;
    end else begin
      selfS1_r <= selfPowered;
      selfS2_r <= selfS1_r;
    end
  end

  // Max packet per endpoint type: 0 ctrl, 1 iso, 2 bulk, 3 int
  function automatic logic [8:0] maxPkt(input logic [3:0] ep);
    logic [31:0] types;
    types = `UEP_EP_TYPES;
    case (types[{ep, 1'b0} +: 2])
      2'd1:    maxPkt = `UEP_MPS_ISO;
      2'd2:    maxPkt = `UEP_MPS_BULK;
      2'd3:    maxPkt = `UEP_MPS_INT;
      default: maxPkt = `UEP_MPS_CTRL;
    endcase
  endfunction : maxPkt

  typedef enum logic [2:0] {
    IDLE, SETUP_DATA, DATA_STAGE, STATUS_STAGE
  } uep_state_t;

  uep_pkg::uep_setup_t setupPkt;
  logic                setupDone, isSetupTok, forMe;
  uep_state_t          state_r, state_nxt;
  logic [6:0]          addr_r, addr_nxt, pendAddr_r, pendAddr_nxt;
  logic                addrPend_r, addrPend_nxt;
  logic                pStall_r, pStall_nxt, fwOwn_r, fwOwn_nxt;
  logic                devToHost_r, devToHost_nxt;
  logic [1:0]          cfg_r, cfg_nxt;
  logic [7:0]          alt_r, alt_nxt;
  logic                wake_r, wake_nxt, syncOn_r, syncOn_nxt;
  logic [10:0]         frame_r, frame_nxt;
  logic [15:0]         halt_r, halt_nxt, tx_r, tx_nxt;
  logic                ansV_r, ansV_nxt, fwV_r, fwV_nxt;
  uep_pkg::uep_answer_t ans_r, ans_nxt;
  logic [3:0]          outEp_r, outEp_nxt, reqEp;
  logic                outPend_r, outPend_nxt;
  logic [15:0]         dirIn;

  assign isSetupTok = tokValid && tok.kind == uep_pkg::UEP_TOK_SETUP;
  assign forMe      = tok.addr == addr_r;
  assign reqEp      = setupPkt.index[3:0];
  assign dirIn      = `UEP_EP_DIR_IN;

  uep_setup_collect i_uep_setup_collect (
    .clk       (clk),
    .rstN      (rstN),
    .start     (isSetupTok && forMe),
    .byteValid (rxByteValid && state_r == SETUP_DATA),
    .byteData  (rxByte),
    .pktEnd    (rxPktEnd && rxPktOk && state_r == SETUP_DATA),
    .setupPkt  (setupPkt),
    .setupDone (setupDone)
  );

  // Control pipe, request decoding and endpoint stall answers
  always_comb begin
    state_nxt = state_r;  addr_nxt = addr_r;  pendAddr_nxt = pendAddr_r;
    addrPend_nxt = addrPend_r;  pStall_nxt = pStall_r;  fwOwn_nxt = fwOwn_r;
    devToHost_nxt = devToHost_r;  cfg_nxt = cfg_r;  alt_nxt = alt_r;
    wake_nxt = wake_r;  syncOn_nxt = syncOn_r;  frame_nxt = frame_r;
    halt_nxt = halt_r;  tx_nxt = tx_r;  outEp_nxt = outEp_r;
    outPend_nxt = outPend_r;
    ansV_nxt = 1'b0;  ans_nxt = '{uep_pkg::UEP_HS_NONE, 1'b0};
    fwV_nxt = 1'b0;
    // Frame capture runs once a synch-frame was seen
    if (syncOn_r && sofValid) frame_nxt = sofFrame;
    if (fwAnswer) begin
      pStall_nxt = pStall_r | fwStall;
    end
    // Other endpoints answer in any control stage, so ep0 cannot block them
    if (tokValid && forMe && tok.ep != 4'h0 &&
        tok.kind == uep_pkg::UEP_TOK_IN) begin
      ansV_nxt = 1'b1;
      ans_nxt.hs = (halt_r[tok.ep] || !dirIn[tok.ep]) ?
                   uep_pkg::UEP_HS_STALL : uep_pkg::UEP_HS_NAK;
    end
    // OUT waits for its data packet; any other token drops it
    if (tokValid && forMe && tok.ep != 4'h0 &&
        tok.kind == uep_pkg::UEP_TOK_OUT) begin
      outEp_nxt   = tok.ep;
      outPend_nxt = 1'b1;
    end else if (tokValid) begin
      outPend_nxt = 1'b0;
    end else if (outPend_r && rxPktEnd) begin
      outPend_nxt = 1'b0;
      if (rxPktOk) begin
        ansV_nxt = 1'b1;
        ans_nxt.hs = (halt_r[outEp_r] || dirIn[outEp_r]) ?
                     uep_pkg::UEP_HS_STALL : uep_pkg::UEP_HS_NAK;
      end
    end
    case (state_r)
      SETUP_DATA: begin
        if (setupDone) begin
          ansV_nxt = 1'b1;
          ans_nxt.hs = uep_pkg::UEP_HS_ACK;
          devToHost_nxt = setupPkt.reqType[7];
          state_nxt = (setupPkt.length != 16'h0000) ? DATA_STAGE : STATUS_STAGE;
          tx_nxt = 16'h0000;
          if (setupPkt.reqType[6:5] != 2'b00) begin
            fwOwn_nxt = 1'b1;
            fwV_nxt = 1'b1;
          end else begin
            case (setupPkt.request)
              `UEP_REQ_SET_ADDRESS: begin
                pendAddr_nxt = setupPkt.value[6:0];
                addrPend_nxt = 1'b1;
              end
              `UEP_REQ_SET_FEATURE, `UEP_REQ_CLR_FEATURE: begin
                if (setupPkt.reqType[1:0] == 2'd0 &&
                    setupPkt.value == `UEP_FEAT_REMOTE_WAKE)
                  wake_nxt = setupPkt.request[1];
                else if (setupPkt.reqType[1:0] == 2'd2 &&
                         setupPkt.value == `UEP_FEAT_EP_HALT && reqEp != 4'h0)
                  halt_nxt[reqEp] = setupPkt.request[1];
                else
                  pStall_nxt = 1'b1;
              end
              `UEP_REQ_GET_STATUS: begin
                if (setupPkt.reqType[1:0] == 2'd2)
                  tx_nxt = {8'h00, dirIn[reqEp], 3'b000, reqEp}
                           | {15'h0000, halt_r[reqEp]};
                else
                  tx_nxt = {14'h0000, wake_r, selfS2_r};
              end
              `UEP_REQ_SET_CONFIG: begin
                if (setupPkt.value[7:0] > {6'h00, `UEP_NUM_CONFIGS})
                  pStall_nxt = 1'b1;
                else begin
                  cfg_nxt = setupPkt.value[1:0];
                  alt_nxt = 8'h00;
                end
              end
              `UEP_REQ_GET_CONFIG: tx_nxt = {14'h0000, cfg_r};
              `UEP_REQ_SET_INTF: alt_nxt = setupPkt.value[7:0];
              `UEP_REQ_GET_INTF: tx_nxt = {8'h00, alt_r};
              `UEP_REQ_SYNCH_FRAME: syncOn_nxt = 1'b1;
              `UEP_REQ_GET_DESC, `UEP_REQ_SET_DESC: begin
                if (setupPkt.value[15:8] == `UEP_DESC_INTERFACE ||
                    setupPkt.value[15:8] == `UEP_DESC_ENDPOINT)
                  pStall_nxt = 1'b1;
                else begin
                  fwOwn_nxt = 1'b1;
                  fwV_nxt = 1'b1;
                end
              end
              default: pStall_nxt = 1'b1;
            endcase
          end
        end else if (rxPktEnd && !rxPktOk) begin
          state_nxt = IDLE; // Corrupt setup: no handshake
        end
      end
      DATA_STAGE, STATUS_STAGE: begin
        if (tokValid && forMe && tok.ep == 4'h0 &&
            tok.kind != uep_pkg::UEP_TOK_SETUP) begin
          ansV_nxt = 1'b1;
          if (pStall_r) ans_nxt.hs = uep_pkg::UEP_HS_STALL;
          else if (fwOwn_r && !fwAnswer) ans_nxt.hs = uep_pkg::UEP_HS_NAK;
          else if ((tok.kind == uep_pkg::UEP_TOK_IN) == devToHost_r &&
                   state_r == DATA_STAGE) begin
            ans_nxt.hs = uep_pkg::UEP_HS_ACK;
            ans_nxt.dataPid1 = 1'b1;
            state_nxt = STATUS_STAGE;
          end else begin
            ans_nxt.hs = uep_pkg::UEP_HS_ACK;
            ans_nxt.dataPid1 = 1'b1;
            state_nxt = IDLE;
            if (addrPend_r) begin
              addr_nxt = pendAddr_r;
              addrPend_nxt = 1'b0;
            end
          end
        end
      end
      default: state_nxt = IDLE;
    endcase
    // A new setup to ep0 always restarts the pipe and lifts protocol stall
    if (isSetupTok && forMe && tok.ep == 4'h0) begin
      state_nxt = SETUP_DATA;
      pStall_nxt = 1'b0;
      fwOwn_nxt = 1'b0;
      addrPend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= IDLE;  addr_r <= 7'h00;  pendAddr_r <= 7'h00;
      addrPend_r <= 1'b0;  pStall_r <= 1'b0;  fwOwn_r <= 1'b0;
      devToHost_r <= 1'b0;  cfg_r <= 2'h0;  alt_r <= 8'h00;
      wake_r <= 1'b0;  syncOn_r <= 1'b0;  frame_r <= 11'h000;
      halt_r <= 16'h0000;  tx_r <= 16'h0000;  outEp_r <= 4'h0;
      outPend_r <= 1'b0;
      ansV_r <= 1'b0;  ans_r <= '{uep_pkg::UEP_HS_NONE, 1'b0};
      fwV_r <= 1'b0;
    end else begin
      state_r <= state_nxt;  addr_r <= addr_nxt;  pendAddr_r <= pendAddr_nxt;
      addrPend_r <= addrPend_nxt;  pStall_r <= pStall_nxt;
      fwOwn_r <= fwOwn_nxt;  devToHost_r <= devToHost_nxt;
      cfg_r <= cfg_nxt;  alt_r <= alt_nxt;  wake_r <= wake_nxt;
      syncOn_r <= syncOn_nxt;  frame_r <= frame_nxt;  halt_r <= halt_nxt;
      tx_r <= tx_nxt;  outEp_r <= outEp_nxt;  ansV_r <= ansV_nxt;
      outPend_r <= outPend_nxt;
      ans_r <= ans_nxt;  fwV_r <= fwV_nxt;
    end
  end

  // Outputs, all from flip-flops except the fixed size lookup
  assign ansValid     = ansV_r;
  assign ans          = ans_r;
  assign txWord       = tx_r;
  assign fwSetupValid = fwV_r;
  assign fwSetup      = setupPkt;
  assign devAddr      = addr_r;
  assign configSlot   = cfg_r;
  assign altSetting   = alt_r;
  assign frameCount   = frame_r;
  assign epHalted     = halt_r;
  assign remoteWake   = wake_r;
  assign epMaxPkt     = maxPkt(outEp_r);
  logic unusedAck;
  assign unusedAck = hostAck;
endmodule : uep_ctrl
`default_nettype wire

// ---- bench/uep_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Checks handshake answers against halt, address and frame state
module uep_ctrl_sva (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 tokValid,
  input var  uep_pkg::uep_token_t  tok,
  input wire logic                 rxPktEnd,
  input wire logic                 sofValid,
  input wire logic [10:0]          sofFrame,
  input wire logic                 ansValid,
  input var  uep_pkg::uep_answer_t ans,
  input wire logic                 fwSetupValid,
  input wire logic [6:0]           devAddr,
  input wire logic [10:0]          frameCount,
  input wire logic [15:0]          epHalted,
  input wire logic [8:0]           epMaxPkt
);
  logic tokHere;
  logic outHalt_r;
  logic outHalt_nxt;
  // An OUT to a halted endpoint is owed a stall once its packet ends
  always_comb begin
    tokHere = tokValid && tok.addr == devAddr;
    outHalt_nxt = outHalt_r;
    if (tokValid) begin
      outHalt_nxt = tokHere && tok.kind == uep_pkg::UEP_TOK_OUT
                    && epHalted[tok.ep];
    end else if (rxPktEnd) begin
      outHalt_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outHalt_r <= 1'b0;
    end else begin
      outHalt_r <= outHalt_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Stall timing on halted endpoints
  in_halt_a: assert property (
    tokHere && tok.kind == uep_pkg::UEP_TOK_IN && epHalted[tok.ep]
    |=> ansValid && ans.hs == uep_pkg::UEP_HS_STALL)
    else $error("halted IN endpoint did not stall at once");
  out_halt_a: assert property (
    rxPktEnd && outHalt_r |=> ansValid && ans.hs == uep_pkg::UEP_HS_STALL)
    else $error("halted OUT endpoint did not stall after data");
  out_wait_a: assert property (
    tokHere && tok.kind == uep_pkg::UEP_TOK_OUT && epHalted[tok.ep]
    |=> !ansValid)
    else $error("halted OUT answered before its data packet");
  // Address, frame, packet-size and request-strobe relations
  addr_late_a: assert property (
    !$stable(devAddr) |-> ansValid && ans.dataPid1)
    else $error("address changed outside a status acknowledge");
  foreign_tok_a: assert property (
    tokValid && tok.addr != devAddr |=> !ansValid)
    else $error("answered a token for another address");
  frame_cap_a: assert property (
    !$stable(frameCount) |-> $past(sofValid) && frameCount == $past(sofFrame))
    else $error("frame counter changed without a frame start");
  max_pkt_a: assert property (
    epMaxPkt inside {9'h008, 9'h040, 9'h100})
    else $error("max packet size outside the fixed set");
  fw_pulse_a: assert property (
    fwSetupValid |=> !fwSetupValid)
    else $error("forwarded request strobe longer than one cycle");
  stall_c: cover property (ansValid && ans.hs == uep_pkg::UEP_HS_STALL);
  addr_c: cover property (!$stable(devAddr));
  fw_c: cover property (fwSetupValid);
endmodule : uep_ctrl_sva
`default_nettype wire

// ---- bench/uep_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side: tokens, data packets and frame starts, driven after edges
module uep_host_model (
  input  wire logic                clk,
  output var  logic                tokValid,
  output var  uep_pkg::uep_token_t tok,
  output var  logic                rxByteValid,
  output var  logic [7:0]          rxByte,
  output var  logic                rxPktEnd,
  output var  logic                rxPktOk,
  output var  logic                sofValid,
  output var  logic [10:0]         sofFrame
);
  // Idle values at time zero
  initial begin
    tokValid = 1'b0;
    tok = '0;
    rxByteValid = 1'b0;
    rxByte = 8'h00;
    rxPktEnd = 1'b0;
    rxPktOk = 1'b0;
    sofValid = 1'b0;
    sofFrame = 11'h000;
  end
  // Released fields are inverted so stale values never look valid
  task automatic sendTok(input uep_pkg::uep_tok_t k, input logic [6:0] a,
                         input logic [3:0] e);
    @(posedge clk);
    tokValid <= 1'b1;
    tok <= '{kind: k, addr: a, ep: e};
    @(posedge clk);
    tokValid <= 1'b0;
    tok <= uep_pkg::uep_token_t'(~tok);
  endtask : sendTok
  // Eight bytes, low byte first; cut drops the last one on purpose
  task automatic sendPkt(input logic [63:0] d, input logic cut);
    for (int i = 0; i < (cut ? 7 : 8); i++) begin
      @(posedge clk);
      rxByteValid <= 1'b1;
      rxByte <= d[8*i +: 8];
    end
    @(posedge clk);
    rxByteValid <= 1'b0;
    rxByte <= ~rxByte;
    rxPktEnd <= 1'b1;
    rxPktOk <= 1'b1;
    @(posedge clk);
    rxPktEnd <= 1'b0;
    rxPktOk <= 1'b0;
  endtask : sendPkt
  task automatic sendSof(input logic [10:0] f);
    @(posedge clk);
    sofValid <= 1'b1;
    sofFrame <= f;
    @(posedge clk);
    sofValid <= 1'b0;
    sofFrame <= ~f;
  endtask : sendSof
endmodule : uep_host_model
`default_nettype wire

// ---- bench/tb_uep_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_uep_ctrl;
  typedef struct packed {
    logic [63:0] pkt;
    logic [15:0] halt;
    logic        wake;
    logic [1:0]  cfg;
    logic [7:0]  alt;
  } uep_row_t;
  logic clk, reset_n, selfPowered, hostAck, fwAnswer, fwStall, fwSeen;
  logic tokValid, rxByteValid, rxPktEnd, rxPktOk, sofValid;
  logic ansValid, fwSetupValid, remoteWake;
  uep_pkg::uep_token_t  tok;
  uep_pkg::uep_answer_t ans, lastAns;
  uep_pkg::uep_setup_t  fwSetup;
  logic [7:0]  rxByte, altSetting;
  logic [10:0] sofFrame, frameCount;
  logic [15:0] txWord, epHalted;
  logic [6:0]  devAddr, hAddr;
  logic [1:0]  configSlot;
  logic [8:0]  epMaxPkt;
  int          fails, checks;
  uep_row_t    rows [6];
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  uep_host_model i_uep_host_model (.clk(clk), .tokValid(tokValid), .tok(tok),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxPktEnd(rxPktEnd),
    .rxPktOk(rxPktOk), .sofValid(sofValid), .sofFrame(sofFrame));
  uep_ctrl i_uep_ctrl (.clk(clk), .reset_n(reset_n), .selfPowered(selfPowered),
    .tokValid(tokValid), .tok(tok), .rxByteValid(rxByteValid),
    .rxByte(rxByte), .rxPktEnd(rxPktEnd), .rxPktOk(rxPktOk),
    .hostAck(hostAck), .sofValid(sofValid), .sofFrame(sofFrame),
    .fwAnswer(fwAnswer), .fwStall(fwStall), .ansValid(ansValid), .ans(ans),
    .txWord(txWord), .fwSetupValid(fwSetupValid), .fwSetup(fwSetup),
    .devAddr(devAddr), .configSlot(configSlot), .altSetting(altSetting),
    .frameCount(frameCount), .epHalted(epHalted), .remoteWake(remoteWake),
    .epMaxPkt(epMaxPkt));
  // Remembers a forwarded-request strobe, which lasts one cycle only
  always @(posedge clk) fwSeen <= fwSeen | (fwSetupValid === 1'b1);
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chkVal
  task automatic chkHs(input uep_pkg::uep_hs_t got,
                       input uep_pkg::uep_hs_t exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: handshake %0d want %0d", $time, got, exp);
    end
  endtask : chkHs
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // Bounded wait; a missing answer ends the run
  task automatic waitAns;
    @(negedge clk);
    for (int i = 0; i < 20 && ansValid !== 1'b1; i++) @(negedge clk);
    lastAns = ans;
    if (ansValid !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: no answer", $time);
      finish_test();
    end
  endtask : waitAns
  task automatic noAns(input int n);
    repeat (n) @(negedge clk) chkVal(16'(ansValid), 16'h0000);
  endtask : noAns
  task automatic setupStage(input logic [63:0] d);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_SETUP, hAddr, 4'h0);
    i_uep_host_model.sendPkt(d, 1'b0);
    waitAns();
    chkHs(lastAns.hs, uep_pkg::UEP_HS_ACK);
  endtask : setupStage
  task automatic inTok(input logic [3:0] e, input uep_pkg::uep_hs_t exp);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_IN, hAddr, e);
    waitAns();
    chkHs(lastAns.hs, exp);
    if (exp == uep_pkg::UEP_HS_ACK && e == 4'h0)
      chkVal(16'(lastAns.dataPid1), 16'h0001);
    @(negedge clk);
  endtask : inTok
  initial begin
    {reset_n, hostAck, fwAnswer, fwStall, fwSeen} = '0;
    selfPowered = 1'b0;
    hAddr = 7'h00;
    fails = 0;
    checks = 0;
    rows = '{'{64'h0000_0081_0000_0302, 16'h0002, 1'b0, 2'h0, 8'h00},
             '{64'h0000_0002_0000_0302, 16'h0006, 1'b0, 2'h0, 8'h00},
             '{64'h0000_0000_0001_0300, 16'h0006, 1'b1, 2'h0, 8'h00},
             '{64'h0000_0000_0002_0900, 16'h0006, 1'b1, 2'h2, 8'h00},
             '{64'h0000_0000_0003_0B01, 16'h0006, 1'b1, 2'h2, 8'h03},
             '{64'h0000_0000_0001_0100, 16'h0006, 1'b0, 2'h2, 8'h03}};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    chkHs(ans.hs, uep_pkg::UEP_HS_NONE);
    chkVal(16'(configSlot), 16'h0000);
    // Hardware-decoded requests, one row each
    foreach (rows[i]) begin
      setupStage(rows[i].pkt);
      inTok(4'h0, uep_pkg::UEP_HS_ACK);
      chkVal(epHalted, rows[i].halt);
      chkVal(16'(remoteWake), 16'(rows[i].wake));
      chkVal(16'(configSlot), 16'(rows[i].cfg));
      chkVal(16'(altSetting), 16'(rows[i].alt));
    end
    // New address waits for the status stage, then old address is ignored
    setupStage(64'h0000_0000_002A_0500);
    chkVal(16'(devAddr), 16'h0000);
    inTok(4'h0, uep_pkg::UEP_HS_ACK);
    chkVal(16'(devAddr), 16'h002A);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_IN, 7'h00, 4'h0);
    noAns(3);
    hAddr = 7'h2A;
    // Halted IN stalls on the token, halted OUT only after its data
    inTok(4'h1, uep_pkg::UEP_HS_STALL);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_OUT, hAddr, 4'h2);
    noAns(2);
    i_uep_host_model.sendPkt(64'h0123_4567_89AB_CDEF, 1'b0);
    waitAns();
    chkHs(lastAns.hs, uep_pkg::UEP_HS_STALL);
    chkVal(16'(epMaxPkt), 16'h0008);
    for (int k = 0; k < 2; k++) begin
      i_uep_host_model.sendTok(uep_pkg::UEP_TOK_OUT, hAddr, k ? 4'h6 : 4'h4);
      i_uep_host_model.sendPkt(64'h0000_0000_0000_0000, 1'b0);
      waitAns();
      chkVal(16'(epMaxPkt), k ? 16'h0040 : 16'h0100);
    end
    // Clearing the halt ends the stall on that endpoint only
    setupStage(64'h0000_0081_0000_0102);
    inTok(4'h0, uep_pkg::UEP_HS_ACK);
    chkVal(epHalted, 16'h0004);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_IN, hAddr, 4'h1);
    waitAns();
    chkVal(16'(lastAns.hs == uep_pkg::UEP_HS_STALL), 16'h0000);
    // IN to an OUT-only endpoint is refused
    inTok(4'h4, uep_pkg::UEP_HS_STALL);
    // Status words: device (self powered) then halted endpoint two
    @(posedge clk);
    selfPowered <= 1'b1;
    setupStage(64'h0002_0000_0000_0080);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_IN, hAddr, 4'h0);
    waitAns();
    chkVal(txWord, 16'h0001);
    setupStage(64'h0002_0002_0000_0082);
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_IN, hAddr, 4'h0);
    waitAns();
    chkVal(txWord, 16'h0003);
    // A seven-byte setup is refused
    i_uep_host_model.sendTok(uep_pkg::UEP_TOK_SETUP, hAddr, 4'h0);
    i_uep_host_model.sendPkt(64'h0000_0000_0001_0900, 1'b1);
    noAns(4);
    // An endpoint descriptor on its own gets a protocol stall
    setupStage(64'h0000_0000_0500_0680);
    inTok(4'h0, uep_pkg::UEP_HS_STALL);
    // Forwarded request: NAK until firmware answers, then protocol stall
    setupStage(64'h0009_0000_0200_0680);
    inTok(4'h0, uep_pkg::UEP_HS_NAK);
    chkVal(16'(fwSeen), 16'h0001);
    chkVal(fwSetup.value, 16'h0200);
    chkVal(fwSetup.length, 16'h0009);
    @(posedge clk);
    fwAnswer <= 1'b1;
    fwStall <= 1'b1;
    @(posedge clk);
    fwAnswer <= 1'b0;
    fwStall <= 1'b0;
    inTok(4'h0, uep_pkg::UEP_HS_STALL);
    inTok(4'h0, uep_pkg::UEP_HS_STALL);
    setupStage(64'h0000_0000_0001_0900);
    inTok(4'h0, uep_pkg::UEP_HS_ACK);
    chkVal(16'(configSlot), 16'h0001);
    // Frame numbers are captured only after a frame-sync request
    i_uep_host_model.sendSof(11'h123);
    repeat (2) @(negedge clk);
    chkVal(16'(frameCount), 16'h0000);
    setupStage(64'h0002_0006_0000_0C82);
    i_uep_host_model.sendSof(11'h7FF);
    repeat (2) @(negedge clk);
    chkVal(16'(frameCount), 16'h07FF);
    i_uep_host_model.sendSof(11'h001);
    repeat (2) @(negedge clk);
    chkVal(16'(frameCount), 16'h0001);
    // Second reset in mid-run
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    chkVal(16'(devAddr), 16'h0000);
    chkVal(epHalted, 16'h0000);
    finish_test();
  end
endmodule : tb_uep_ctrl
bind uep_ctrl uep_ctrl_sva i_uep_ctrl_sva (.clk(clk), .reset_n(reset_n),
  .tokValid(tokValid), .tok(tok), .rxPktEnd(rxPktEnd), .sofValid(sofValid),
  .sofFrame(sofFrame), .ansValid(ansValid), .ans(ans),
  .fwSetupValid(fwSetupValid), .devAddr(devAddr), .frameCount(frameCount),
  .epHalted(epHalted), .epMaxPkt(epMaxPkt));
`default_nettype wire
